/* File: src/tmr_core.v */
// Purpose: 8-bit timer/counter with two compare units and flags
// Assumes: tick sources arrive as one-cycle enables from a shared prescaler
// Notes:   no bus; control and status are plain ports
//
// Functional notes
// - One counter, two compare units, three flags
// - Bottom indicated at zero
// - Max indicated at 0xff
// - Top is 0xff or compare A
// - Source zero stops the counter
// - Clear, increment or decrement per tick
// - Counter write beats clear and count
// - Mode from three bits over two registers
// - Overflow flag set per mode
// - Equality sets match flag next tick
// - Match flags clear on service or one
// - Flags gated by own mask bits
// - Compare buffered only in pwm modes
// - Buffer transfers at top
// - Access hits buffer when buffered
// - Force strobe acts as match in non-pwm modes, no flag
// - Counter write blocks next tick match
// - Output states kept over mode change
// - Output mode change acts at once
// - Output from match, mode and setting
// - Normal mode wraps, overflow at zero
// - Clear-on-match mode clears at compare A
// - Fast pwm single slope to top
// - Reset clears output states
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"

module tmr_core (
  input  wire       clk_sys,
  input  wire       rst,
  // Tick sources: selects 2..5 prescaled, 6 falling pin edge, 7 rising
  input  wire       tick_div8,
  input  wire       tick_div64,
  input  wire       tick_div256,
  input  wire       tick_div1024,
  input  wire       pin_fall_tick,
  input  wire       pin_rise_tick,
  // Control
  input  wire [2:0] tick_source_select,
  input  wire [2:0] waveform_mode,
  input  wire [1:0] compare_output_mode_a,
  input  wire [1:0] compare_output_mode_b,
  input  wire       force_compare_a,
  input  wire       force_compare_b,
  // Counter access
  input  wire       count_wr,
  input  wire [7:0] count_wdata,
  // Compare access
  input  wire       compare_a_wr,
  input  wire       compare_b_wr,
  input  wire [7:0] compare_wdata,
  // Flag and mask access
  input  wire       flag_wr,
  input  wire [2:0] flag_wdata,
  input  wire       mask_wr,
  input  wire [2:0] mask_wdata,
  input  wire       ack_overflow,
  input  wire       ack_match_a,
  input  wire       ack_match_b,
  // Status
  output reg  [7:0] count_value,
  output reg  [7:0] compare_value_a,
  output reg  [7:0] compare_value_b,
  output reg  [2:0] timer_flag_reg,
  output reg  [2:0] timer_mask_reg,
  output wire [1:0] force_compare_rdata,
  output wire       at_bottom,
  output wire       at_max,
  output wire       irq_overflow,
  output wire       irq_match_a,
  output wire       irq_match_b,
  output wire       compare_out_a,
  output wire       compare_out_b
);

  reg        timer_tick;
  reg        count_down;
  reg        block_match;
  reg  [7:0] next_count;
  reg        next_down;
  reg        ovf_event;
  reg  [2:0] next_flags;
  wire [7:0] active_a;
  wire [7:0] active_b;
  wire [7:0] rdata_a;
  wire [7:0] rdata_b;
  wire       match_a;
  wire       match_b;
  wire       pwm_mode;
  wire       fast_mode;
  wire       pc_mode;
  wire       top_is_a;
  wire [7:0] top_value;
  wire       at_top;
  wire       update_point;
  wire [2:0] set_bits;
  wire [2:0] clr_bits;

  always @* begin
    case (tick_source_select)
      `TMR_CS_NONE:   timer_tick = 1'b0;
      `TMR_CS_DIRECT: timer_tick = 1'b1;
      3'h2:           timer_tick = tick_div8;
      3'h3:           timer_tick = tick_div64;
      3'h4:           timer_tick = tick_div256;
      3'h5:           timer_tick = tick_div1024;
      3'h6:           timer_tick = pin_fall_tick;
      default:        timer_tick = pin_rise_tick;
    endcase
  end

  assign fast_mode = (waveform_mode == `TMR_WGM_FAST_MAX) ||
                     (waveform_mode == `TMR_WGM_FAST_OCRA);
  assign pc_mode   = (waveform_mode == `TMR_WGM_PC_MAX) ||
                     (waveform_mode == `TMR_WGM_PC_OCRA);
  assign pwm_mode  = fast_mode || pc_mode;
  assign top_is_a  = (waveform_mode == `TMR_WGM_CTC) ||
                     (waveform_mode == `TMR_WGM_FAST_OCRA) ||
                     (waveform_mode == `TMR_WGM_PC_OCRA);
  assign top_value = top_is_a ? active_a : `TMR_MAX;
  assign at_top    = (count_value == top_value);
  assign at_bottom = (count_value == `TMR_BOTTOM);
  assign at_max    = (count_value == `TMR_MAX);
  // Update at top in fast pwm, at top in phase correct
  assign update_point = timer_tick && at_top;

  always @* begin
    next_count = count_value;
    next_down  = count_down;
    ovf_event  = 1'b0;
    if (timer_tick) begin
      if (pc_mode) begin
        if (count_down) begin
          if (at_bottom) begin
            next_down  = 1'b0;
            next_count = count_value + 8'h01;
          end else begin
            next_count = count_value - 8'h01;
            // overflow at bottom when dual slope
            ovf_event  = (count_value == 8'h01);
          end
        end else if (at_top) begin
          next_down  = 1'b1;
          next_count = count_value - 8'h01;
        end else begin
          next_count = count_value + 8'h01;
        end
      end else if (fast_mode) begin
        next_down = 1'b0;
        if (at_top) begin
          next_count = `TMR_BOTTOM;
          ovf_event  = 1'b1;
        end else begin
          next_count = count_value + 8'h01;
        end
      end else if (waveform_mode == `TMR_WGM_CTC) begin
        next_down = 1'b0;
        if (count_value == active_a) begin
          next_count = `TMR_BOTTOM;
        end else begin
          next_count = count_value + 8'h01;
        end
        ovf_event = at_max;
      end else begin
        next_down  = 1'b0;
        next_count = count_value + 8'h01;
        ovf_event  = at_max;
      end
    end
    if (count_wr) begin
      next_count = count_wdata;
    end
  end

  // Counter, direction, match blocking
  always @(posedge clk_sys) begin
    if (rst) begin
      count_value <= `TMR_RST_BYTE;
      count_down  <= 1'b0;
      block_match <= 1'b0;
    end else begin
      count_value <= next_count;
      count_down  <= next_down;
      if (count_wr) begin
        block_match <= 1'b1;
      end else if (timer_tick) begin
        block_match <= 1'b0;
      end
    end
  end

  // Flag set and clear terms
  assign set_bits = {match_b, match_a, ovf_event && !(count_wr && timer_tick)};
  // clear on service or written one
  assign clr_bits = ({3{flag_wr}} & flag_wdata) |
                    {ack_match_b, ack_match_a, ack_overflow};

  // Set beats clear in the same cycle
  always @* begin
    next_flags = (timer_flag_reg & ~clr_bits) | set_bits;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      timer_flag_reg <= 3'h0;
      timer_mask_reg <= 3'h0;
    end else begin
      timer_flag_reg <= next_flags;
      if (mask_wr) begin
        timer_mask_reg <= mask_wdata;
      end
    end
  end

  assign irq_overflow = timer_flag_reg[`TMR_BIT_OVF] & timer_mask_reg[`TMR_BIT_OVF];
  assign irq_match_a  = timer_flag_reg[`TMR_BIT_MATCH_A] & timer_mask_reg[`TMR_BIT_MATCH_A];
  assign irq_match_b  = timer_flag_reg[`TMR_BIT_MATCH_B] & timer_mask_reg[`TMR_BIT_MATCH_B];

  assign force_compare_rdata = 2'h0;

  // Registered compare readback
  always @(posedge clk_sys) begin
    if (rst) begin
      compare_value_a <= `TMR_RST_BYTE;
      compare_value_b <= `TMR_RST_BYTE;
    end else begin
      compare_value_a <= rdata_a;
      compare_value_b <= rdata_b;
    end
  end

  // Compare unit A
  tmr_compare_unit u_cmp_a (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .timer_tick           (timer_tick),
    .pwm_mode             (pwm_mode),
    .fast_mode            (fast_mode),
    .count_down           (count_down),
    .update_point         (update_point),
    .at_bottom            (at_bottom),
    .block_match          (block_match),
    .count_value          (count_value),
    .cmp_wr               (compare_a_wr),
    .cmp_wdata            (compare_wdata),
    .compare_output_mode  (compare_output_mode_a),
    .force_compare_strobe (force_compare_a),
    .compare_active       (active_a),
    .compare_rdata        (rdata_a),
    .match_set            (match_a),
    .compare_out          (compare_out_a)
  );

  // Compare unit B
  tmr_compare_unit u_cmp_b (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .timer_tick           (timer_tick),
    .pwm_mode             (pwm_mode),
    .fast_mode            (fast_mode),
    .count_down           (count_down),
    .update_point         (update_point),
    .at_bottom            (at_bottom),
    .block_match          (block_match),
    .count_value          (count_value),
    .cmp_wr               (compare_b_wr),
    .cmp_wdata            (compare_wdata),
    .compare_output_mode  (compare_output_mode_b),
    .force_compare_strobe (force_compare_b),
    .compare_active       (active_b),
    .compare_rdata        (rdata_b),
    .match_set            (match_b),
    .compare_out          (compare_out_b)
  );

endmodule // tmr_core

`default_nettype wire

/* File: pkg/tmr_defines.vh */
// Purpose: constants for the 8-bit timer/counter core
// Assumes: included by the core and its compare unit
// Notes:   definitions only
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

`define TMR_BOTTOM        8'h00
`define TMR_MAX           8'hff
`define TMR_RST_BYTE      8'h00
`define TMR_RST_MODE      3'h0
`define TMR_RST_CS        3'h0

// Waveform modes
`define TMR_WGM_NORMAL    3'h0
`define TMR_WGM_PC_MAX    3'h1
`define TMR_WGM_CTC       3'h2
`define TMR_WGM_FAST_MAX  3'h3
`define TMR_WGM_PC_OCRA   3'h5
`define TMR_WGM_FAST_OCRA 3'h7

// Tick sources
`define TMR_CS_NONE       3'h0
`define TMR_CS_DIRECT     3'h1

// Compare output modes
`define TMR_COM_NONE      2'h0
`define TMR_COM_TOGGLE    2'h1
`define TMR_COM_CLEAR     2'h2
`define TMR_COM_SET       2'h3

// Flag and mask bit positions
`define TMR_BIT_OVF       0
`define TMR_BIT_MATCH_A   1
`define TMR_BIT_MATCH_B   2

`endif

/* File: src/tmr_compare_unit.v */
// Purpose: one compare unit: buffered compare value, match, output state
// Assumes: tick and mode qualifiers supplied by the core
// Notes:   output state survives mode changes, cleared by reset and by the match and bottom logic
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"

module tmr_compare_unit (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       timer_tick,
  input  wire       pwm_mode,
  input  wire       fast_mode,
  input  wire       count_down,
  input  wire       update_point,
  input  wire       at_bottom,
  input  wire       block_match,
  input  wire [7:0] count_value,
  input  wire       cmp_wr,
  input  wire [7:0] cmp_wdata,
  input  wire [1:0] compare_output_mode,
  input  wire       force_compare_strobe,
  output reg  [7:0] compare_active,
  output wire [7:0] compare_rdata,
  output wire       match_set,
  output reg        compare_out
);

  reg [7:0] compare_buffer;
  reg       next_out;
  wire      equal;
  wire      real_match;
  wire      do_match;

  assign equal        = (count_value == compare_active);
  assign real_match   = equal && timer_tick && !block_match;
  assign match_set    = real_match;
  assign do_match     = real_match || (force_compare_strobe && !pwm_mode);
  assign compare_rdata = pwm_mode ? compare_buffer : compare_active;

  // Compare value and its buffer
  always @(posedge clk_sys) begin
    if (rst) begin
      compare_active <= `TMR_RST_BYTE;
      compare_buffer <= `TMR_RST_BYTE;
    end else begin
      if (cmp_wr) begin
        compare_buffer <= cmp_wdata;
      end
      if (cmp_wr && !pwm_mode) begin
        compare_active <= cmp_wdata;
      end else if (pwm_mode && update_point) begin
        compare_active <= compare_buffer;
      end
    end
  end

  always @* begin
    next_out = compare_out;
    if (!pwm_mode) begin
      if (do_match) begin
        case (compare_output_mode)
          `TMR_COM_TOGGLE: next_out = !compare_out;
          `TMR_COM_CLEAR:  next_out = 1'b0;
          `TMR_COM_SET:    next_out = 1'b1;
          default:         next_out = compare_out;
        endcase
      end
    end else if (compare_output_mode[1]) begin
      if (fast_mode) begin
        if (do_match) begin
          next_out = compare_output_mode[0];
        end else if (timer_tick && at_bottom) begin
          next_out = !compare_output_mode[0];
        end
      end else if (do_match) begin
        next_out = count_down ? !compare_output_mode[0] : compare_output_mode[0];
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      compare_out <= 1'b0;
    end else begin
      compare_out <= next_out;
    end
  end

endmodule // tmr_compare_unit

`default_nettype wire

/* File: dv/tmr_core_monitor.sv */
// Purpose: port-level checks for the 8-bit timer core
// Assumes: one clock domain, sync active-high reset
// Notes:   bound to every instance of the core
`timescale 1ns/1ps
`default_nettype none

module tmr_core_monitor (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [2:0] tick_source_select,
  input wire logic [2:0] waveform_mode,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic       force_compare_a,
  input wire logic       count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic       compare_a_wr,
  input wire logic [7:0] count_value,
  input wire logic [7:0] compare_value_a,
  input wire logic [2:0] timer_flag_reg,
  input wire logic [2:0] timer_mask_reg,
  input wire logic       at_bottom,
  input wire logic       at_max,
  input wire logic       irq_overflow,
  input wire logic       irq_match_a,
  input wire logic       irq_match_b,
  input wire logic       compare_out_a
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_BOTTOM: assert property (at_bottom == (count_value == 8'h00))
    else $error("bottom indication wrong");
  AST_MAX: assert property (at_max == (count_value == 8'hff))
    else $error("max indication wrong");
  AST_HOLD: assert property (tick_source_select == 3'h0 && !count_wr |=> $stable(count_value))
    else $error("counter moved without a tick");
  AST_LOAD: assert property (count_wr |=> count_value == $past(count_wdata))
    else $error("counter load lost");
  AST_INC: assert property (waveform_mode == 3'h0 && tick_source_select == 3'h1 && !count_wr
    |=> count_value == $past(count_value) + 8'h01)
    else $error("normal mode step wrong");
  AST_OVF: assert property (waveform_mode == 3'h0 && tick_source_select == 3'h1 && !count_wr
    && count_value == 8'hff |=> timer_flag_reg[0])
    else $error("overflow flag not set at wrap");
  AST_IRQ: assert property ({irq_match_b, irq_match_a, irq_overflow}
    == (timer_flag_reg & timer_mask_reg))
    else $error("interrupt request not flag and mask");
  AST_MATCH: assert property (waveform_mode == 3'h0 && tick_source_select == 3'h1 && !count_wr
    && !$past(count_wr) && !$past(compare_a_wr) && !$past(compare_a_wr, 2)
    && $past(tick_source_select) == 3'h1 && $past(waveform_mode) == 3'h0
    && count_value == compare_value_a |=> timer_flag_reg[1])
    else $error("match flag a not set");
  AST_FORCE: assert property (force_compare_a && waveform_mode == 3'h0
    && compare_output_mode_a[1] |=> compare_out_a == ($past(compare_output_mode_a) == 2'h3))
    else $error("forced compare output wrong");
endmodule // tmr_core_monitor

bind tmr_core tmr_core_monitor i_tmr_core_monitor (
  .clk_sys(clk_sys), .rst(rst), .tick_source_select(tick_source_select),
  .waveform_mode(waveform_mode), .compare_output_mode_a(compare_output_mode_a),
  .force_compare_a(force_compare_a), .count_wr(count_wr), .count_wdata(count_wdata),
  .compare_a_wr(compare_a_wr), .count_value(count_value), .compare_value_a(compare_value_a),
  .timer_flag_reg(timer_flag_reg), .timer_mask_reg(timer_mask_reg), .at_bottom(at_bottom),
  .at_max(at_max), .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
  .irq_match_b(irq_match_b), .compare_out_a(compare_out_a)
);
`default_nettype wire

/* File: dv/tmr_core_tb_top.sv */
// Purpose: self-checking bench for the 8-bit timer core
// Assumes: inputs change on the falling edge of clk_sys
// Notes:   prescaler and pin ticks come from a free bench counter
`timescale 1ns/1ps
`default_nettype none

module tmr_core_tb_top;
  logic       clk_sys     = 1'b0;
  logic       rst         = 1'b1;
  logic [9:0] div         = 10'h000;
  logic [2:0] sel         = 3'h0;
  logic [2:0] wgm         = 3'h0;
  logic [1:0] coma        = 2'h0;
  logic [1:0] comb        = 2'h0;
  logic [7:0] dat         = 8'h00;
  logic [9:0] stb         = 10'h000;
  logic [7:0] cnt, cva, cvb;
  logic [2:0] flg, msk;
  logic [1:0] frd;
  logic       bot, mx, iov, ima, imb, oa, ob;
  int         n_fail      = 0;
  int         checks_done = 0;

  // Strobes: 0 count,1 cmp a,2 cmp b,3 flag,4 mask,5/6 force,7..9 acks
  tmr_core i_tmr_core (
    .clk_sys(clk_sys), .rst(rst), .tick_div8(div[2:0] == 3'h0),
    .tick_div64(div[5:0] == 6'h00), .tick_div256(div[7:0] == 8'h00),
    .tick_div1024(div == 10'h000), .pin_fall_tick(div[1:0] == 2'h1),
    .pin_rise_tick(div[1:0] == 2'h3), .tick_source_select(sel), .waveform_mode(wgm),
    .compare_output_mode_a(coma), .compare_output_mode_b(comb),
    .force_compare_a(stb[5]), .force_compare_b(stb[6]), .count_wr(stb[0]),
    .count_wdata(dat), .compare_a_wr(stb[1]), .compare_b_wr(stb[2]), .compare_wdata(dat),
    .flag_wr(stb[3]), .flag_wdata(dat[2:0]), .mask_wr(stb[4]), .mask_wdata(dat[2:0]),
    .ack_overflow(stb[7]), .ack_match_a(stb[8]), .ack_match_b(stb[9]),
    .count_value(cnt), .compare_value_a(cva), .compare_value_b(cvb),
    .timer_flag_reg(flg), .timer_mask_reg(msk), .force_compare_rdata(frd),
    .at_bottom(bot), .at_max(mx), .irq_overflow(iov), .irq_match_a(ima),
    .irq_match_b(imb), .compare_out_a(oa), .compare_out_b(ob)
  );

  always #10 clk_sys = ~clk_sys;
  // Free tick counter
  always @(negedge clk_sys) div <= div + 10'h001;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle strobe with data, then an idle cycle
  task automatic wr(input int k, input logic [7:0] d);
    dat = d;
    stb[k] = 1'b1;
    cyc(1);
    stb = 10'h000;
    cyc(1);
  endtask
  // Highest count seen over n cycles
  task automatic runmax(input int n, input logic [7:0] exp);
    logic [7:0] m;
    m = 8'h00;
    repeat (n) begin
      cyc(1);
      if (cnt > m) m = cnt;
    end
    chk(m, exp);
  endtask
  task automatic results;
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    #1000000;
    n_fail++;
    results();
  end

  // Main sequence
  initial begin
    int per [6] = '{8, 64, 256, 1024, 4, 4};
    cyc(6);
    rst = 1'b0;
    chk({bot, oa, ob, flg}, 8'h20);
    wr(4, 8'h07);
    wr(0, 8'hfd);
    chk(cnt, 8'hfd);
    sel = 3'h1;
    cyc(3);
    sel = 3'h0;
    chk(cnt, 8'h00);
    chk({iov, flg}, 8'h09);
    wr(7, 8'h00);
    chk(flg, 8'h00);
    // Compare A match toggles output
    coma = 2'h1;
    wr(1, 8'h10);
    wr(0, 8'h0e);
    sel = 3'h1;
    cyc(6);
    sel = 3'h0;
    chk({ima, oa, flg}, 8'h1a);
    wr(3, 8'h05);
    chk(flg, 8'h02);
    wr(3, 8'h02);
    chk(flg, 8'h00);
    // Counter write blocks the next match
    comb = 2'h3;
    wr(2, 8'h20);
    chk(cvb, 8'h20);
    wr(0, 8'h20);
    sel = 3'h1;
    cyc(4);
    sel = 3'h0;
    chk({ob, flg}, 8'h00);
    // Forced compare, then refused in pwm
    coma = 2'h2;
    wr(5, 8'h00);
    wr(6, 8'h00);
    chk({oa, ob, flg}, 8'h08);
    wgm = 3'h3;
    coma = 2'h3;
    wr(5, 8'h00);
    chk({oa, ob, frd}, 8'h04);
    // Clear-on-match and fast pwm tops
    wgm = 3'h2;
    coma = 2'h0;
    comb = 2'h0;
    wr(1, 8'h05);
    wr(0, 8'h00);
    sel = 3'h1;
    runmax(20, 8'h05);
    wgm = 3'h7;
    runmax(20, 8'h05);
    sel = 3'h0;
    wr(0, 8'h02);
    wr(1, 8'h09);
    chk(cva, 8'h09);
    sel = 3'h1;
    runmax(4, 8'h05);
    runmax(20, 8'h09);
    // Each prescaled and pin tick source advances twice
    wgm = 3'h0;
    sel = 3'h0;
    for (int s = 2; s < 8; s++) begin
      wr(0, 8'h00);
      sel = s[2:0];
      cyc(2 * per[s - 2]);
      sel = 3'h0;
      chk(cnt, 8'h02);
    end
    cyc(5);
    chk(cnt, 8'h02);
    results();
  end
endmodule // tmr_core_tb_top
`default_nettype wire
